// *** sim/front_end_model.sv ***
// shunt sample source standing behind the converter inputs
module front_end_model (
  input  wire logic               core_clk,
  input  wire logic signed [15:0] level,
  output logic signed [15:0]      shunt_sample = 16'sh0000,
  output logic                    bus_sample_valid = 1'b1
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // sample moves off the sampling edge
  // ****
  always @(negedge core_clk) shunt_sample <= level;
endmodule // front_end_model

// *** sim/monitor_adc_config_shunt_format_test.sv ***
// bench of the configuration and shunt result block
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin miscompares++; \
  $display("BAD %s exp %h got %h", n, e, a); end end
module monitor_adc_config_shunt_format_test
  import monitor_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic               core_clk = 1'b0, srst = 1'b1, reg_wr = 1'b0;
  logic [7:0]         reg_ptr = 8'h00;
  logic [15:0]        reg_wdata = 16'h0000, reg_rdata, q;
  logic signed [15:0] level = 16'sh0000, shunt_sample;
  logic               bus_sample_valid, shunt_conv_busy, bus_conv_busy;
  logic               shunt_updated, bus_updated, bus_range_select, sb, bb;
  logic [1:0]         gain_sel;
  int                 miscompares = 0, n_compared = 0, ticks = 0, len;
  always #4 core_clk = ~core_clk;
  always @(posedge core_clk) if (++ticks > 20000) begin
    miscompares++;
    results();
  end
  monitor_config #(.CYC_9(24'd4), .CYC_10(24'd5), .CYC_11(24'd6),
    .CYC_12(24'd8)) DUT (.core_clk, .srst, .reg_ptr, .reg_wr, .reg_wdata,
    .reg_rdata, .shunt_sample, .bus_sample_valid, .shunt_conv_busy,
    .bus_conv_busy, .shunt_updated, .bus_updated, .bus_range_select,
    .gain_sel);
  front_end_model u_fe (.core_clk, .level, .shunt_sample, .bus_sample_valid);
  task automatic wr(input logic [15:0] d);
    @(negedge core_clk);
    reg_ptr = PTR_CONFIG;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] p);
    @(negedge core_clk);
    reg_ptr = p;
    repeat (2) @(negedge core_clk);
    q = reg_rdata;
  endtask
  task automatic conv(input logic [15:0] cfg);
    wr(cfg);
    reg_ptr = PTR_SHUNT;
    len = 0;
    repeat (3000) begin
      @(negedge core_clk);
      len += int'(shunt_conv_busy | bus_conv_busy);
      if (shunt_updated | bus_updated) break;
    end
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_reset();
    rd(PTR_CONFIG);
    `CHK("config", 16'h399f, q)
    `CHK("gain", 2'b11, gain_sel)
    rd(PTR_SHUNT);
    `CHK("shunt", 16'h0000, q)
  endtask
  task automatic t_timing();
    int tab[4] = '{4, 5, 6, 8};
    wr(16'h1800);
    repeat (12) @(negedge core_clk);
    for (int s = 0; s < 16; s++) begin
      conv(16'h1801 | 16'(s << 3));
      `CHK("time", s[3] ? 8 << s[2:0] : tab[s[1:0]], len)
      `CHK("shunt upd", 1'b1, shunt_updated)
    end
    conv(16'h1d02);
    `CHK("bus time", 32, len)
    `CHK("bus upd", 1'b1, bus_updated)
  endtask
  task automatic t_gain();
    logic [15:0] pos[4] = '{16'h0fa0, 16'h1f40, 16'h3e80, 16'h7d00};
    logic [15:0] neg[4] = '{16'hf060, 16'he0c0, 16'hc180, 16'h8300};
    for (int g = 0; g < 4; g++) begin
      level = 16'sh7fff;
      conv(16'(g << 11) | 16'h0001);
      rd(PTR_SHUNT);
      `CHK("pos", pos[g], q)
      level = 16'sh8001;
      conv(16'(g << 11) | 16'h0001);
      rd(PTR_SHUNT);
      `CHK("neg", neg[g], q)
    end
  endtask
  task automatic t_modes();
    for (int m = 0; m < 8; m++) begin
      wr(16'h3800);
      repeat (12) @(negedge core_clk);
      wr(16'h3800 | 16'(m));
      sb = 1'b0;
      bb = 1'b0;
      repeat (12) begin
        @(negedge core_clk);
        sb |= shunt_conv_busy;
        bb |= bus_conv_busy;
      end
      `CHK("shunt start", 1'(m), sb)
      `CHK("bus start", 1'(m >> 1), bb)
      sb = 1'b0;
      bb = 1'b0;
      repeat (40) begin
        @(negedge core_clk);
        sb |= shunt_conv_busy;
        bb |= bus_conv_busy;
      end
      `CHK("shunt run", 1'(m >> 2 & m), sb)
      `CHK("bus run", 1'(m >> 2 & m >> 1), bb)
    end
  endtask
  task automatic t_soft();
    wr(16'h0000);
    `CHK("range off", 1'b0, bus_range_select)
    wr(16'h8000);
    rd(PTR_CONFIG);
    `CHK("soft reset", 16'h399f, q)
    wr(16'h7fff);
    rd(PTR_CONFIG);
    `CHK("masked", 16'h3fff, q)
    rd(8'h07);
    `CHK("unmapped", 16'h0000, q)
  endtask
  task automatic results();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge core_clk);
    srst = 1'b0;
    t_reset();
    t_timing();
    t_gain();
    t_modes();
    t_soft();
    results();
  end
endmodule // monitor_adc_config_shunt_format_test

// *** sim/monitor_config_chk.sv ***
// port assertions of the configuration and shunt block
module monitor_config_chk
  import monitor_pkg::*;
#(parameter logic [23:0] CYC_9 = 24'(T9_CYC))
(
  input wire logic               core_clk,
  input wire logic               srst,
  input wire logic [7:0]         reg_ptr,
  input wire logic               reg_wr,
  input wire logic [15:0]        reg_wdata,
  input wire logic [15:0]        reg_rdata,
  input wire logic signed [15:0] shunt_sample,
  input wire logic               bus_sample_valid,
  input wire logic               shunt_conv_busy,
  input wire logic               bus_conv_busy,
  input wire logic               shunt_updated,
  input wire logic               bus_updated,
  input wire logic               bus_range_select,
  input wire logic [1:0]         gain_sel
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  logic [23:0] run_q;
  always_ff @(posedge core_clk)
    run_q <= shunt_conv_busy ? run_q + 24'h1 : 24'h0;
  function automatic logic [15:0] clip(logic signed [15:0] v, logic [1:0] g);
    logic signed [15:0] l;
    l = 16'sh0fa0 <<< g;
    return (v > l) ? l : ((v < -l) ? -l : v);
  endfunction
  sequence s_cfg_wr;
    reg_wr && reg_ptr == PTR_CONFIG;
  endsequence
  a_gain_follows: assert property (s_cfg_wr and !reg_wdata[15] |=>
    gain_sel == $past(reg_wdata[12:11])) else $error("gain field wrong");
  a_range_follows: assert property (s_cfg_wr and !reg_wdata[15] |=>
    bus_range_select == $past(reg_wdata[13])) else $error("range bit wrong");
  a_soft_reset: assert property (s_cfg_wr and reg_wdata[15] |=>
    gain_sel == 2'b11 && bus_range_select) else $error("soft reset missed");
  a_shunt_clip: assert property ($past(shunt_updated, 2)
    && reg_ptr == PTR_SHUNT && $past(reg_ptr) == PTR_SHUNT |->
    reg_rdata == clip($past(shunt_sample, 2), $past(gain_sel, 2)))
    else $error("shunt format");
  a_upd_pulse: assert property (shunt_updated |=> !shunt_updated)
    else $error("update pulse too long");
  a_upd_at_end: assert property (shunt_updated |-> $fell(shunt_conv_busy))
    else $error("update not at conversion end");
  a_bus_end: assert property (bus_updated |-> !bus_conv_busy)
    else $error("bus update while busy");
  a_busy_length: assert property ($fell(shunt_conv_busy) |->
    run_q + 24'h1 >= CYC_9) else $error("conversion too short");
endmodule // monitor_config_chk
bind monitor_config monitor_config_chk #(.CYC_9(CYC_9)) u_chk (.core_clk,
  .srst, .reg_ptr, .reg_wr, .reg_wdata, .reg_rdata, .shunt_sample,
  .bus_sample_valid, .shunt_conv_busy, .bus_conv_busy, .shunt_updated,
  .bus_updated, .bus_range_select, .gain_sel);

// *** src/conv_timer.sv ***
// conversion time counter for one converter channel
module conv_timer
  import monitor_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic        start,
  input  wire logic [3:0]  setting,
  input  wire logic [23:0] cyc_9,
  input  wire logic [23:0] cyc_10,
  input  wire logic [23:0] cyc_11,
  input  wire logic [23:0] cyc_12,
  output logic             busy,
  output logic             done
);

  logic [31:0] count_q;
  logic [31:0] count_d;
  logic        busy_q;
  logic        busy_d;
  logic        done_q;
  logic        done_d;
  logic [31:0] span;

  // ****************************************
  // length of one conversion sequence
  // ****************************************
  always_comb begin
    span = {8'h00, cyc_12};
    if (!setting[3]) begin
      case (setting[1:0])
        2'b00:   span = {8'h00, cyc_9};
        2'b01:   span = {8'h00, cyc_10};
        2'b10:   span = {8'h00, cyc_11};
        default: span = {8'h00, cyc_12};
      endcase
    end else begin
      span = {8'h00, cyc_12} << setting[2:0];
    end
  end

  always_comb begin
    count_d = count_q;
    busy_d  = busy_q;
    done_d  = 1'b0;
    if (start && !busy_q) begin
      busy_d  = 1'b1;
      count_d = span - 32'd1;
    end else if (busy_q) begin
      if (count_q == 32'd0) begin
        busy_d = 1'b0;
        done_d = 1'b1;
      end else begin
        count_d = count_q - 32'd1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      count_q <= 32'd0;
      busy_q  <= 1'b0;
      done_q  <= 1'b0;
    end else begin
      count_q <= count_d;
      busy_q  <= busy_d;
      done_q  <= done_d;
    end
  end

  assign busy = busy_q;
  assign done = done_q;

endmodule // conv_timer

// *** src/monitor_config.sv ***
// measurement configuration and shunt result format
// ****************************************
// Summary of operation
// ****************************************
// Summary of operation
// - gain field selects 40 to 320 mV
// - bits 7-10 set bus conversion
// - bits 3-6 set shunt conversion
// - top bit 0: 9-12 bit times
// - top bit 1: averaging 1 to 128
// - mode field picks off, triggered, continuous
// - shunt result clipped by gain
// - two's complement, sign extended 16 bits
// - div8 spans 32000 counts
// - div4 spans 16000 counts
// - div2 spans 8000 counts
// - gain 1 spans 4000 counts
// - bit 15 reloads config defaults only, self-clears
// - bit 13 bus range, default 32 V
// - gain defaults to divide by 8
module monitor_config
  import monitor_pkg::*;
#(
  parameter logic [23:0] CYC_9  = 24'(T9_CYC),
  parameter logic [23:0] CYC_10 = 24'(T10_CYC),
  parameter logic [23:0] CYC_11 = 24'(T11_CYC),
  parameter logic [23:0] CYC_12 = 24'(T12_CYC)
)
(
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic [7:0]  reg_ptr,
  input  wire logic        reg_wr,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  input  wire logic signed [15:0] shunt_sample,
  input  wire logic        bus_sample_valid,
  output logic             shunt_conv_busy,
  output logic             bus_conv_busy,
  output logic             shunt_updated,
  output logic             bus_updated,
  output logic             bus_range_select,
  output logic      [1:0]  gain_sel
);

  // ****************************************
  // state, next values and helpers
  // ****************************************
  logic [15:0] config_q;
  logic [15:0] config_d;
  logic [15:0] shunt_reading_q;
  logic [15:0] shunt_reading_d;
  logic        trig_q;
  logic        trig_d;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic [3:0]  bus_conv_setting;
  logic [3:0]  shunt_conv_setting;
  mode_type    mode;
  logic        gain_sel_hi;
  logic        gain_sel_lo;
  logic        run_shunt;
  logic        run_bus;
  logic        sh_done;
  logic        bu_done;
  logic signed [15:0] limit;
  logic signed [15:0] clipped;
  logic [1:0]  run_ch;
  logic [1:0]  busy_ch;
  logic [1:0]  done_ch;
  logic [1:0][3:0] setting_ch;

  // ****************************************
  // configuration fields
  // ****************************************
  assign gain_sel_hi        = config_q[GAIN_LO+1];
  assign gain_sel_lo        = config_q[GAIN_LO];
  assign bus_conv_setting   = config_q[BUS_SET_LO+3:BUS_SET_LO];
  assign shunt_conv_setting = config_q[SHUNT_SET_LO+3:SHUNT_SET_LO];
  assign mode               = mode_type'(config_q[MODE_LO+2:MODE_LO]);

  // ****************************************
  // configuration register
  // ****************************************
  always_comb begin
    config_d = config_q;
    trig_d   = 1'b0;
    if (reg_wr && reg_ptr == PTR_CONFIG) begin
      if (reg_wdata[RESET_BIT]) begin
        config_d = CONFIG_RESET;
      end else begin
        config_d = reg_wdata & CONFIG_WR_MASK;
        trig_d   = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      config_q <= CONFIG_RESET;
      trig_q   <= 1'b0;
    end else begin
      config_q <= config_d;
      trig_q   <= trig_d;
    end
  end

  // ****************************************
  // conversion sequencing
  // ****************************************
  always_comb begin
    run_shunt = 1'b0;
    run_bus   = 1'b0;
    case (mode)
      mode_trig_shunt: run_shunt = trig_q;
      mode_trig_bus:   run_bus   = trig_q;
      mode_trig_both: begin
        run_shunt = trig_q;
        run_bus   = trig_q;
      end
      mode_cont_shunt: run_shunt = 1'b1;
      mode_cont_bus:   run_bus   = 1'b1;
      mode_cont_both: begin
        run_shunt = 1'b1;
        run_bus   = 1'b1;
      end
      default: begin
        run_shunt = 1'b0;
        run_bus   = 1'b0;
      end
    endcase
  end

  // ****************************************
  // one timer per converter channel
  // ****************************************
  assign run_ch     = {run_bus, run_shunt};
  assign setting_ch = {bus_conv_setting, shunt_conv_setting};

  for (genvar ch = 0; ch < 2; ch++) begin : g_timer
    conv_timer u_timer (
      .core_clk (core_clk),
      .srst     (srst),
      .start    (run_ch[ch]),
      .setting  (setting_ch[ch]),
      .cyc_9    (CYC_9),
      .cyc_10   (CYC_10),
      .cyc_11   (CYC_11),
      .cyc_12   (CYC_12),
      .busy     (busy_ch[ch]),
      .done     (done_ch[ch])
    );
  end

  assign shunt_conv_busy = busy_ch[0];
  assign bus_conv_busy   = busy_ch[1];
  assign sh_done         = done_ch[0];
  assign bu_done         = done_ch[1];

  // ****************************************
  // shunt result formatting
  // ****************************************
  always_comb begin
    case ({gain_sel_hi, gain_sel_lo})
      2'b00:   limit = LIMIT_DIV1;
      2'b01:   limit = LIMIT_DIV2;
      2'b10:   limit = LIMIT_DIV4;
      default: limit = LIMIT_DIV8;
    endcase
    if (shunt_sample > limit) begin
      clipped = limit;
    end else if (shunt_sample < -limit) begin
      clipped = -limit;
    end else begin
      clipped = shunt_sample;
    end
    shunt_reading_d = shunt_reading_q;
    if (sh_done) begin
      shunt_reading_d = clipped;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      shunt_reading_q <= 16'h0000;
    end else begin
      shunt_reading_q <= shunt_reading_d;
    end
  end

  // ****************************************
  // read data register
  // ****************************************
  always_comb begin
    rdata_d = 16'h0000;
    if (reg_ptr == PTR_CONFIG) begin
      rdata_d = config_q;
    end else if (reg_ptr == PTR_SHUNT) begin
      rdata_d = shunt_reading_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ****************************************
  // status outputs
  // ****************************************
  assign reg_rdata        = rdata_q;
  assign shunt_updated    = sh_done;
  assign bus_updated      = bu_done & bus_sample_valid;
  assign bus_range_select = config_q[RANGE_BIT];
  assign gain_sel         = {gain_sel_hi, gain_sel_lo};

endmodule // monitor_config

// *** src/monitor_pkg.sv ***
// constants shared by the measurement configuration block
package monitor_pkg;

  // ****************************************
  // register pointers and layout
  // ****************************************
  localparam logic [7:0]  PTR_CONFIG      = 8'h00;
  localparam logic [7:0]  PTR_SHUNT       = 8'h01;
  localparam logic [15:0] CONFIG_RESET    = 16'h399f;
  localparam int          RESET_BIT       = 15;
  localparam int          RANGE_BIT       = 13;
  localparam int          GAIN_LO         = 11;
  localparam int          BUS_SET_LO      = 7;
  localparam int          SHUNT_SET_LO    = 3;
  localparam int          MODE_LO         = 0;
  localparam logic [15:0] CONFIG_WR_MASK  = 16'hbfff;

  // ****************************************
  // shunt limits per gain, in 10 uV counts
  // ****************************************
  localparam logic signed [15:0] LIMIT_DIV1 = 16'sh0fa0;
  localparam logic signed [15:0] LIMIT_DIV2 = 16'sh1f40;
  localparam logic signed [15:0] LIMIT_DIV4 = 16'sh3e80;
  localparam logic signed [15:0] LIMIT_DIV8 = 16'sh7d00;

  // ****************************************
  // conversion times
  // ****************************************
  localparam int CLK_MHZ     = 125;
  localparam int T9_US       = 84;
  localparam int T10_US      = 148;
  localparam int T11_US      = 276;
  localparam int T12_US      = 532;
  localparam int T12_CYC     = T12_US * CLK_MHZ;
  localparam int T9_CYC      = T9_US * CLK_MHZ;
  localparam int T10_CYC     = T10_US * CLK_MHZ;
  localparam int T11_CYC     = T11_US * CLK_MHZ;

  typedef enum logic [2:0] {
    mode_power_down, mode_trig_shunt, mode_trig_bus, mode_trig_both,
    mode_adc_off, mode_cont_shunt, mode_cont_bus, mode_cont_both
  } mode_type;

endpackage
